// [logic/smsd_map.svh]
// Constants for the status, mask and sweep command decoder
`ifndef SMSD_MAP_SVH
`define SMSD_MAP_SVH
`define SMSD_A_CMD      12'h000
`define SMSD_A_ARG      12'h004
`define SMSD_A_STAT1    12'h008
`define SMSD_A_STAT2    12'h00c
`define SMSD_A_SMASK    12'h010
`define SMSD_A_XMASK    12'h014
`define SMSD_A_STEPSZ   12'h018
`define SMSD_A_NSTEP    12'h01c
`define SMSD_A_FREQ     12'h020
`define SMSD_A_START    12'h024
`define SMSD_A_STOP     12'h028
`define SMSD_A_SWEEP    12'h02c
`define SMSD_A_STEPINC  12'h030
`define SMSD_A_IRQST    12'h034
`define SMSD_A_IRQEN    12'h038
`define SMSD_A_IRQCLR   12'h03c
`define SMSD_A_OUTBYTE  12'h040
`define SMSD_C_SMASK    4'h1
`define SMSD_C_XMASK    4'h2
`define SMSD_C_KNOB     4'h3
`define SMSD_C_RESTART  4'h4
`define SMSD_C_STEPSZ   4'h5
`define SMSD_C_SINGLE   4'h6
`define SMSD_C_MANUAL   4'h7
`define SMSD_C_NSTEP    4'h8
`define SMSD_C_OSTAT    4'h9
`define SMSD_C_UP       4'ha
`define SMSD_C_DOWN     4'hb
`define SMSD_C_NEXT     4'hc
`define SMSD_C_CLEAR    4'hd
`define SMSD_C_AUTO     4'he
`define SMSD_C_START    4'hf
`define SMSD_NSTEP_MIN  16'h000a
`define SMSD_NSTEP_MAX  16'h03e8
`define SMSD_STEP_MIN   36'h0_0000_0001
`define SMSD_STEP_MAX   36'h2_540b_e400
`define SMSD_B_XCHG     2
`define SMSD_B_SYNTAX   5
`define SMSD_B_RQS      6
`define SMSD_B_UNLVL    6
`define SMSD_LATCH2     8'h71
`define SMSD_NSTEP_RST  16'h0191
`define SMSD_STEP_RST   36'h0_000f_4240
`define SMSD_DIV_STEPS  6'h24
`endif

// [logic/smsd_pkg.sv]
// Types for the status, mask and sweep command decoder
package smsd_pkg;
   typedef enum logic [1:0] {
      SMSD_IDLE = 2'b00,
      SMSD_RUN  = 2'b01,
      SMSD_HOLD = 2'b10
   } smsd_sweep_t;
   typedef struct packed {
      logic [7:0] stat1;
      logic [7:0] stat2;
      logic [7:0] smask;
      logic [7:0] xmask;
      logic       xchg_seen;
      logic       read_once;
   } smsd_status_t;
   typedef struct packed {
      smsd_status_t st;
      logic [35:0]  stepsz;
      logic         auto_step;
      logic [15:0]  nstep;
      logic [35:0]  freq;
      logic [35:0]  fstart;
      logic [35:0]  fstop;
      logic [35:0]  stepinc;
      smsd_sweep_t  sweep;
      logic         single_mode;
      logic         manual_mode;
      logic         stepped;
      logic [15:0]  step_idx;
      logic [7:0]   out_byte;
      logic         out_valid;
      logic         out_second;
      logic [2:0]   irq_st;
      logic [2:0]   irq_en;
      logic         irq;
      logic         srq;
      logic [31:0]  prdata;
      logic         pready;
      logic         pslverr;
      logic [7:0]   hw2_q;
      logic         div_busy;
      logic [5:0]   div_cnt;
      logic [35:0]  div_rem;
   } smsd_state_t;
endpackage : smsd_pkg

// [logic/smsd_top.sv]
// Status mask and sweep command decoder with APB register access
`timescale 1ns/1ps
`default_nettype none
`include "smsd_map.svh"
module smsd_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [7:0]  hw_status2,
   input  wire logic        sweep_done,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             srq,
   output logic             irq,
   output logic [35:0]      freq,
   output logic [1:0]       sweep_state,
   output logic [7:0]       out_byte,
   output logic             out_valid
);
   smsd_pkg::smsd_state_t s_reg;
   smsd_pkg::smsd_state_t s_next;
   logic [31:0] arg_reg;

   // Add a signed delta, clamped at zero
   function automatic logic [35:0] smsd_move(input logic [35:0] f, input logic [35:0] d,
                                             input logic up);
      logic [36:0] r;
      r = 37'h0;
      if (up) begin
         r = {1'b0, f} + {1'b0, d};
      end else if (f > d) begin
         r = {1'b0, f} - {1'b0, d};
      end
      return r[35:0];
   endfunction

   function automatic logic [35:0] smsd_span(input logic [35:0] a, input logic [35:0] b);
      return (b > a) ? (b - a) : (a - b);
   endfunction

   logic        acc;
   logic        wr;
   logic        rd;
   logic        mapped;
   logic [3:0]  cmd;
   logic [7:0]  s2_live;
   logic [7:0]  s1_out;
   logic [7:0]  knob;
   logic [35:0] knob_mag;
   logic [35:0] arg36;
   logic [35:0] act_step;

   assign acc = psel & penable & ~s_reg.pready;
   assign wr  = acc & pwrite;
   assign rd  = acc & ~pwrite;
   assign cmd = pwdata[3:0];
   assign knob = arg_reg[7:0];
   assign arg36 = {4'h0, arg_reg};
   // Knob byte: 0x80 is taken as +128, others two's complement
   assign knob_mag = (knob == 8'h80) ? 36'h80 :
                     (knob[7] ? {28'h0, (~knob + 8'h01)} : {28'h0, knob});
   assign act_step = s_reg.auto_step ? (smsd_span(s_reg.fstart, s_reg.fstop) >> 4)
                                     : s_reg.stepsz;
   assign s2_live = s_reg.st.stat2;
   assign s1_out  = s_reg.st.stat1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arg_reg <= 32'h0;
      end else if (wr && paddr == `SMSD_A_ARG) begin
         arg_reg <= pwdata;
      end
   end

   always_comb begin
      logic [7:0] chg;
      logic       xev;
      logic       synerr;
      logic       do_read;
      logic       sweep_ev;
      logic [35:0] mul;
      chg = 8'h0;
      xev = 1'b0;
      synerr = 1'b0;
      do_read = 1'b0;
      sweep_ev = 1'b0;
      mul = 36'h0;
      s_next = s_reg;
      s_next.pready = acc;
      s_next.pslverr = 1'b0;
      s_next.out_valid = 1'b0;
      s_next.hw2_q = hw_status2;
      // Latched bits hold, others follow live inputs
      s_next.st.stat2 = (s_reg.st.stat2 & `SMSD_LATCH2) | hw_status2;
      chg = (s_next.st.stat2 ^ s_reg.st.stat2) & s_reg.st.xmask;
      xev = |chg;
      // Restoring division span / nstep; stepinc holds a partial quotient while busy
      if (s_reg.div_busy) begin
         mul = {s_reg.div_rem[34:0], s_reg.stepinc[35]};
         s_next.stepinc = {s_reg.stepinc[34:0], 1'b0};
         if (mul >= {20'h0, s_reg.nstep}) begin
            mul = mul - {20'h0, s_reg.nstep};
            s_next.stepinc[0] = 1'b1;
         end
         s_next.div_rem = mul;
         s_next.div_cnt = s_reg.div_cnt - 6'h01;
         if (s_reg.div_cnt == 6'h01) begin
            s_next.div_busy = 1'b0;
         end
      end
      if (s_reg.sweep == smsd_pkg::SMSD_RUN && sweep_done) begin
         s_next.sweep = s_reg.single_mode ? smsd_pkg::SMSD_HOLD : smsd_pkg::SMSD_RUN;
         s_next.freq = s_reg.fstart;
         sweep_ev = 1'b1;
      end
      if (s_reg.out_second) begin
         s_next.out_byte = s_reg.st.stat2;
         s_next.out_valid = 1'b1;
         s_next.out_second = 1'b0;
         do_read = 1'b1;
      end
      if (wr) begin
         case (paddr)
            `SMSD_A_CMD: begin
               case (cmd)
                  `SMSD_C_SMASK: s_next.st.smask = arg_reg[7:0];
                  `SMSD_C_XMASK: s_next.st.xmask = arg_reg[7:0];
                  `SMSD_C_KNOB:  s_next.freq = smsd_move(s_reg.freq,
                                    36'(knob_mag * act_step), ~knob[7] | (knob == 8'h80));
                  `SMSD_C_RESTART: begin
                     s_next.freq = s_reg.fstart;
                     s_next.sweep = s_reg.single_mode ? smsd_pkg::SMSD_HOLD
                                                      : smsd_pkg::SMSD_RUN;
                     s_next.step_idx = 16'h0;
                  end
                  `SMSD_C_STEPSZ: begin
                     if (arg36 >= `SMSD_STEP_MIN && arg36 <= `SMSD_STEP_MAX) begin
                        s_next.stepsz = arg36;
                        s_next.auto_step = 1'b0;
                     end else begin
                        synerr = 1'b1;
                     end
                  end
                  `SMSD_C_AUTO: s_next.auto_step = 1'b1;
                  `SMSD_C_SINGLE: begin
                     s_next.freq = s_reg.fstart;
                     s_next.manual_mode = 1'b0;
                     s_next.single_mode = 1'b1;
                     // First command only arms; later ones start one sweep if none is running, or stop a running sweep in HOLD
                     s_next.sweep = (s_reg.single_mode && s_reg.sweep != smsd_pkg::SMSD_RUN)
                                    ? smsd_pkg::SMSD_RUN : smsd_pkg::SMSD_HOLD;
                  end
                  `SMSD_C_MANUAL: begin
                     s_next.manual_mode = 1'b1;
                     s_next.sweep = smsd_pkg::SMSD_HOLD;
                     s_next.freq = s_reg.fstart;
                  end
                  `SMSD_C_NSTEP: begin
                     if (arg_reg[31:16] == 16'h0 && arg_reg[15:0] >= `SMSD_NSTEP_MIN &&
                         arg_reg[15:0] <= `SMSD_NSTEP_MAX) begin
                        s_next.nstep = arg_reg[15:0];
                        s_next.stepped = 1'b1;
                        s_next.step_idx = 16'h0;
                        s_next.freq = s_reg.fstart;
                        s_next.div_busy = 1'b1;
                        s_next.div_cnt = `SMSD_DIV_STEPS;
                        s_next.div_rem = 36'h0;
                        s_next.stepinc = smsd_span(s_reg.fstart, s_reg.fstop);
                     end else begin
                        synerr = 1'b1;
                     end
                  end
                  `SMSD_C_OSTAT: begin
                     s_next.out_byte = s1_out;
                     s_next.out_valid = 1'b1;
                     s_next.out_second = 1'b1;
                  end
                  `SMSD_C_UP:   s_next.freq = smsd_move(s_reg.freq, act_step, 1'b1);
                  `SMSD_C_DOWN: s_next.freq = smsd_move(s_reg.freq, act_step, 1'b0);
                  `SMSD_C_NEXT: begin
                     if (s_reg.stepped && s_reg.step_idx < s_reg.nstep && !s_reg.div_busy) begin
                        s_next.freq = smsd_move(s_reg.freq, s_reg.stepinc, 1'b1);
                        s_next.step_idx = s_reg.step_idx + 16'h0001;
                     end
                  end
                  `SMSD_C_CLEAR: begin
                     s_next.st.stat1 = 8'h0;
                     s_next.st.stat2 = hw_status2;
                     s_next.st.read_once = 1'b0;
                  end
                  `SMSD_C_START: s_next.fstart = arg36;
                  default: synerr = 1'b1;
               endcase
            end
            `SMSD_A_STOP:   s_next.fstop = arg36;
            `SMSD_A_IRQEN:  s_next.irq_en = pwdata[2:0];
            `SMSD_A_IRQCLR: s_next.irq_st = s_reg.irq_st & ~pwdata[2:0];
            `SMSD_A_ARG: ;
            default: s_next.pslverr = 1'b1;
         endcase
      end
      if (rd && paddr == `SMSD_A_STAT2) begin
         do_read = 1'b1;
      end
      // Second read of the byte releases latched bits
      if (do_read) begin
         if (s_reg.st.read_once) begin
            s_next.st.stat2 = hw_status2;
            s_next.st.read_once = 1'b0;
         end else begin
            s_next.st.read_once = 1'b1;
         end
      end
      // Event sets win over any clear in the same cycle
      if (xev) begin
         s_next.st.stat1[`SMSD_B_XCHG] = 1'b1;
      end
      if (synerr) begin
         s_next.st.stat1[`SMSD_B_SYNTAX] = 1'b1;
         s_next.irq_st[1] = 1'b1;
      end
      if (sweep_ev) begin
         s_next.irq_st[0] = 1'b1;
      end
      s_next.st.stat1[`SMSD_B_RQS] =
         |(s_next.st.stat1 & s_next.st.smask & ~(8'h1 << `SMSD_B_RQS));
      s_next.srq = s_next.st.stat1[`SMSD_B_RQS];
      if (s_next.srq && !s_reg.srq) begin
         s_next.irq_st[2] = 1'b1;
      end
      s_next.irq = |(s_next.irq_st & s_next.irq_en);
      mapped = 1'b1;
      case (paddr)
         `SMSD_A_ARG:     s_next.prdata = arg_reg;
         `SMSD_A_STAT1:   s_next.prdata = {24'h0, s_reg.st.stat1};
         `SMSD_A_STAT2:   s_next.prdata = {24'h0, s_reg.st.stat2};
         `SMSD_A_SMASK:   s_next.prdata = {24'h0, s_reg.st.smask};
         `SMSD_A_XMASK:   s_next.prdata = {24'h0, s_reg.st.xmask};
         `SMSD_A_STEPSZ:  s_next.prdata = s_reg.stepsz[31:0];
         `SMSD_A_NSTEP:   s_next.prdata = {16'h0, s_reg.nstep};
         `SMSD_A_FREQ:    s_next.prdata = s_reg.freq[31:0];
         `SMSD_A_START:   s_next.prdata = s_reg.fstart[31:0];
         `SMSD_A_STOP:    s_next.prdata = s_reg.fstop[31:0];
         `SMSD_A_SWEEP:   s_next.prdata = {24'h0, s_reg.div_busy, s_reg.auto_step,
                                          s_reg.stepped, s_reg.manual_mode,
                                          s_reg.single_mode, 1'b0, s_reg.sweep};
         `SMSD_A_STEPINC: s_next.prdata = s_reg.stepinc[31:0];
         `SMSD_A_IRQST:   s_next.prdata = {29'h0, s_reg.irq_st};
         `SMSD_A_IRQEN:   s_next.prdata = {29'h0, s_reg.irq_en};
         `SMSD_A_OUTBYTE: s_next.prdata = {24'h0, s_reg.out_byte};
         default: begin
            s_next.prdata = 32'h0;
            mapped = 1'b0;
         end
      endcase
      if (rd && !mapped) begin
         s_next.pslverr = 1'b1;
      end
      if (!acc) begin
         s_next.prdata = s_reg.prdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_reg <= '0;
         s_reg.nstep <= `SMSD_NSTEP_RST;
         s_reg.stepsz <= `SMSD_STEP_RST;
      end else begin
         s_reg <= s_next;
      end
   end

   assign prdata = s_reg.prdata;
   assign pready = s_reg.pready;
   assign pslverr = s_reg.pslverr;
   assign srq = s_reg.srq;
   assign irq = s_reg.irq;
   assign freq = s_reg.freq;
   assign sweep_state = s_reg.sweep;
   assign out_byte = s_reg.out_byte;
   assign out_valid = s_reg.out_valid;

   property p_mask_load;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `SMSD_A_CMD && cmd == `SMSD_C_SMASK) |=> (s_reg.st.smask == $past(arg_reg[7:0]));
   endproperty
   a_mask_load: assert property (p_mask_load) else $error("mask not loaded");

   property p_srq_only_enabled;
      @(posedge pclk) disable iff (!presetn)
      srq |-> |(s_reg.st.stat1 & s_reg.st.smask & ~(8'h1 << `SMSD_B_RQS));
   endproperty
   a_srq_only_enabled: assert property (p_srq_only_enabled) else $error("srq without cause");

   property p_ostat_order;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `SMSD_A_CMD && cmd == `SMSD_C_OSTAT) |=> out_valid ##1 out_valid;
   endproperty
   a_ostat_order: assert property (p_ostat_order) else $error("status bytes not sent twice");

   property p_restart;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `SMSD_A_CMD && cmd == `SMSD_C_RESTART) |=> (freq == $past(s_reg.fstart));
   endproperty
   a_restart: assert property (p_restart) else $error("restart did not retrace");

   property p_nstep_range;
      @(posedge pclk) disable iff (!presetn)
      s_reg.nstep >= `SMSD_NSTEP_MIN && s_reg.nstep <= `SMSD_NSTEP_MAX;
   endproperty
   a_nstep_range: assert property (p_nstep_range) else $error("step count out of range");

   property p_bad_arg;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `SMSD_A_CMD && cmd == `SMSD_C_NSTEP && arg_reg > {16'h0, `SMSD_NSTEP_MAX})
         |=> s_reg.st.stat1[`SMSD_B_SYNTAX] && $stable(s_reg.nstep);
   endproperty
   a_bad_arg: assert property (p_bad_arg) else $error("bad step count accepted");

   property p_up_step;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `SMSD_A_CMD && cmd == `SMSD_C_UP && !s_reg.auto_step)
         |=> freq == $past(s_reg.freq) + $past(s_reg.stepsz);
   endproperty
   a_up_step: assert property (p_up_step) else $error("up moved wrong amount");

   property p_unlvl_latch;
      @(posedge pclk) disable iff (!presetn)
      (s_reg.st.stat2[`SMSD_B_UNLVL] && !wr && !rd && !s_reg.out_second)
         |=> s_reg.st.stat2[`SMSD_B_UNLVL];
   endproperty
   a_unlvl_latch: assert property (p_unlvl_latch) else $error("unleveled bit lost");

   // Clears and read releases are left out: they change byte 2 without an event
   property p_xchg_set;
      @(posedge pclk) disable iff (!presetn)
      (!$past(wr) && !$past(rd) && !$past(s_reg.out_second) &&
       (|((s_reg.st.stat2 ^ $past(s_reg.st.stat2)) & $past(s_reg.st.xmask))))
         |-> s_reg.st.stat1[`SMSD_B_XCHG];
   endproperty
   a_xchg_set: assert property (p_xchg_set) else $error("masked change not flagged");

   property p_clear_status;
      @(posedge pclk) disable iff (!presetn)
      (wr && paddr == `SMSD_A_CMD && cmd == `SMSD_C_CLEAR)
         |=> !s_reg.st.stat1[`SMSD_B_SYNTAX] && !s_reg.st.read_once;
   endproperty
   a_clear_status: assert property (p_clear_status) else $error("clear left status");

   property p_div_rem;
      @(posedge pclk) disable iff (!presetn)
      $fell(s_reg.div_busy) |-> (s_reg.div_rem < {20'h0, s_reg.nstep});
   endproperty
   a_div_rem: assert property (p_div_rem) else $error("step division remainder too big");
endmodule // smsd_top
`default_nettype wire

// [test/smsd_ctl_model.sv]
// Remote controller model issuing commands over the register bus
`timescale 1ns/1ps
`default_nettype none
`include "smsd_map.svh"
module smsd_ctl_model (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   logic last_err;
   logic hung;
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      last_err = 1'b0;
      hung = 1'b0;
   end
   // Request held until pready is seen at an edge or 50 edges pass (hung is then set); no fixed cycle count assumed
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      q = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         hung = 1'b1;
      end
   endtask
   // Argument always goes ahead of the code
   task automatic cmd(input logic [3:0] c, input logic [31:0] arg);
      logic [31:0] q;
      xfer(1'b1, `SMSD_A_ARG, arg, q);
      xfer(1'b1, `SMSD_A_CMD, {28'h0, c}, q);
   endtask
   // Single-byte argument, bit n weighs two to n
   task automatic cmd_byte(input logic [3:0] c, input logic [7:0] b);
      cmd(c, {24'h0, b});
   endtask
endmodule // smsd_ctl_model
`default_nettype wire

// [test/status_mask_sweep_cmd_decoder_bench.sv]
// Self-checking bench for the status, mask and sweep command decoder
`timescale 1ns/1ps
`default_nettype none
`include "smsd_map.svh"
module status_mask_sweep_cmd_decoder_bench;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [7:0]  hw_status2;
   logic        sweep_done;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        srq;
   logic        irq;
   logic [35:0] freq;
   logic [1:0]  sweep_state;
   logic [7:0]  out_byte;
   logic        out_valid;
   logic [7:0]  obytes[$];
   logic [31:0] q;
   int          errors;
   int          check_count;
   int          i;
   int          ns_arg [4] = '{9, 1001, 10, 1000};
   int          ns_exp [4] = '{401, 401, 10, 1000};

   smsd_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hw_status2(hw_status2),
      .sweep_done(sweep_done), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .srq(srq), .irq(irq), .freq(freq), .sweep_state(sweep_state),
      .out_byte(out_byte), .out_valid(out_valid));
   smsd_ctl_model ctl_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));

   initial begin
      pclk = 1'b0;
   end
   always #2.5 pclk = ~pclk;

   task automatic final_report();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      ctl_u.xfer(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      ctl_u.xfer(1'b1, a, d, r);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // Output-status bytes are single-cycle pulses
   always @(posedge pclk) begin
      if (out_valid === 1'b1) begin
         obytes.push_back(out_byte);
      end
   end
   always @(posedge ctl_u.hung) begin
      errors++;
      final_report();
   end

   initial begin
      presetn = 1'b0;
      hw_status2 = 8'h00;
      sweep_done = 1'b0;
      errors = 0;
      check_count = 0;
      cyc(10);
      presetn <= 1'b1;
      rdc(`SMSD_A_STEPSZ, 32'h000f4240);
      rdc(`SMSD_A_NSTEP, 32'h00000191);
      ctl_u.xfer(1'b0, 12'h100, 32'h0, q);
      chk(ctl_u.last_err, 1'b1);
      ctl_u.cmd_byte(`SMSD_C_SMASK, 8'h04);
      ctl_u.cmd_byte(`SMSD_C_XMASK, 8'h40);
      rdc(`SMSD_A_SMASK, 32'h04);
      rdc(`SMSD_A_XMASK, 32'h40);
      // Unmasked change must stay silent
      hw_status2 <= 8'h02;
      cyc(6);
      chk(srq, 1'b0);
      hw_status2 <= 8'h42;
      cyc(6);
      chk(srq, 1'b1);
      ctl_u.cmd(`SMSD_C_OSTAT, 32'h0);
      for (i = 0; i < 20 && obytes.size() < 2; i++) cyc(1);
      chk(obytes.size(), 2);
      chk(obytes[0], 8'h44);
      chk(obytes[1], 8'h42);
      hw_status2 <= 8'h00;
      cyc(4);
      ctl_u.cmd(`SMSD_C_CLEAR, 32'h0);
      rdc(`SMSD_A_STAT2, 32'h0);
      rdc(`SMSD_A_STAT1, 32'h0);
      chk(srq, 1'b0);
      ctl_u.cmd(`SMSD_C_CLEAR, 32'h0);
      // Short unleveled blip stays latched until the second read
      hw_status2 <= 8'h40;
      cyc(3);
      hw_status2 <= 8'h00;
      cyc(3);
      rdc(`SMSD_A_STAT2, 32'h40);
      rdc(`SMSD_A_STAT2, 32'h40);
      rdc(`SMSD_A_STAT2, 32'h00);
      ctl_u.cmd(`SMSD_C_CLEAR, 32'h0);
      ctl_u.cmd(`SMSD_C_STEPSZ, 32'h0);
      rdc(`SMSD_A_STEPSZ, 32'h000f4240);
      rdc(`SMSD_A_STAT1, 32'h20);
      ctl_u.cmd(`SMSD_C_STEPSZ, 32'd1000);
      rdc(`SMSD_A_STEPSZ, 32'd1000);
      ctl_u.cmd(`SMSD_C_START, 32'd2000000);
      wr(`SMSD_A_ARG, 32'd12000000);
      wr(`SMSD_A_STOP, 32'h0);
      rdc(`SMSD_A_STOP, 32'd12000000);
      ctl_u.cmd(`SMSD_C_RESTART, 32'h0);
      rdc(`SMSD_A_FREQ, 32'd2000000);
      ctl_u.cmd_byte(`SMSD_C_KNOB, 8'h80);
      rdc(`SMSD_A_FREQ, 32'd2128000);
      ctl_u.cmd_byte(`SMSD_C_KNOB, 8'h81);
      rdc(`SMSD_A_FREQ, 32'd2001000);
      ctl_u.cmd(`SMSD_C_MANUAL, 32'h0);
      rdc(`SMSD_A_FREQ, 32'd2000000);
      ctl_u.cmd(`SMSD_C_UP, 32'h0);
      rdc(`SMSD_A_FREQ, 32'd2001000);
      ctl_u.cmd(`SMSD_C_DOWN, 32'h0);
      rdc(`SMSD_A_FREQ, 32'd2000000);
      ctl_u.cmd(`SMSD_C_AUTO, 32'h0);
      ctl_u.cmd(`SMSD_C_UP, 32'h0);
      rdc(`SMSD_A_FREQ, 32'd2625000);
      for (i = 0; i < 4; i++) begin
         ctl_u.cmd(`SMSD_C_NSTEP, ns_arg[i]);
         rdc(`SMSD_A_NSTEP, ns_exp[i]);
      end
      cyc(50);
      rdc(`SMSD_A_STEPINC, 32'd10000);
      ctl_u.cmd(`SMSD_C_RESTART, 32'h0);
      ctl_u.cmd(`SMSD_C_NEXT, 32'h0);
      rdc(`SMSD_A_FREQ, 32'd2010000);
      ctl_u.cmd(`SMSD_C_NEXT, 32'h0);
      rdc(`SMSD_A_FREQ, 32'd2020000);
      chk(freq, 36'd2020000);
      wr(`SMSD_A_IRQCLR, 32'h7);
      wr(`SMSD_A_IRQEN, 32'h1);
      rdc(`SMSD_A_IRQST, 32'h0);
      ctl_u.cmd(`SMSD_C_SINGLE, 32'h0);
      cyc(2);
      chk(sweep_state, smsd_pkg::SMSD_HOLD);
      ctl_u.cmd(`SMSD_C_SINGLE, 32'h0);
      cyc(2);
      chk(sweep_state, smsd_pkg::SMSD_RUN);
      ctl_u.cmd(`SMSD_C_SINGLE, 32'h0);
      rdc(`SMSD_A_FREQ, 32'd2000000);
      chk(sweep_state, smsd_pkg::SMSD_HOLD);
      ctl_u.cmd(`SMSD_C_SINGLE, 32'h0);
      chk(sweep_state, smsd_pkg::SMSD_RUN);
      sweep_done <= 1'b1;
      cyc(1);
      sweep_done <= 1'b0;
      cyc(4);
      chk(irq, 1'b1);
      rdc(`SMSD_A_IRQST, 32'h1);
      wr(`SMSD_A_IRQCLR, 32'h1);
      cyc(2);
      chk(irq, 1'b0);
      // Masked syntax error must not interrupt
      wr(`SMSD_A_IRQEN, 32'h0);
      ctl_u.cmd(`SMSD_C_NSTEP, 32'd5);
      cyc(2);
      chk(irq, 1'b0);
      rdc(`SMSD_A_IRQST, 32'h2);
      final_report();
   end
   initial begin
      cyc(100000);
      errors++;
      final_report();
   end
endmodule // status_mask_sweep_cmd_decoder_bench
`default_nettype wire
